// ==== rtl/sdmr_regs.sv ====
// Purpose: Device information and burst setup mode registers with burst column ordering.
// Assumes: Decoded mode-register read and write commands, synchronous to clk.
// Notes: Beat address generation covers the 4 and 8 beat orders.
`timescale 1ns/1ps
module sdmr_regs #(
	parameter logic [7:0] INIT_CYCLES = sdmr_pkg::DEFAULT_INIT_CYCLES,
	parameter logic SELFTEST_SUPPORTED = 1'b1,
	parameter logic DEVICE_IS_NVM = 1'b0
) (
	input wire logic clk,
	input wire logic arst_n,
	input sdmr_pkg::sdmr_cmd_t cmd,
	input wire logic zq_cal_start,
	input wire logic zq_cal_done,
	input wire logic [1:0] zq_pin_sense,
	input wire logic wr_ap_end,
	input wire logic burst_start,
	input wire logic [3:0] start_col,
	input wire logic [3:0] beat,
	output logic rd_valid_ff,
	output logic [7:0] rd_data_ff,
	output sdmr_pkg::sdmr_burst_setup_t burst_setup_ff,
	output logic factory_trim_ff,
	output logic zq_cal_active_ff,
	output logic precharge_start_ff,
	output logic [3:0] beat_col_ff,
	output sdmr_pkg::sdmr_burst_status_t burst_status_ff
);
	import sdmr_pkg::*;

	logic [7:0] init_cnt_ff;
	logic [7:0] nxt_init_cnt;
	logic [1:0] selftest_ff;
	logic [1:0] nxt_selftest;
	logic nxt_factory_trim;
	logic nxt_zq_cal_active;
	sdmr_burst_setup_t nxt_burst_setup;
	logic nxt_rd_valid;
	logic [7:0] nxt_rd_data;
	logic [3:0] wr_cnt_ff;
	logic [3:0] nxt_wr_cnt;
	logic nxt_precharge_start;
	logic [3:0] nxt_beat_col;
	sdmr_burst_status_t nxt_burst_status;
	logic [3:0] order_col;
	logic [3:0] even_col;

	function automatic logic [3:0] wr_cycles(input logic [2:0] code);
		wr_cycles = {1'b0, code} + WR_CODE_OFFSET;
	endfunction

	function automatic logic bl_legal(input logic [2:0] code);
		bl_legal = (code == BL_CODE_4) || (code == BL_CODE_8) || (code == BL_CODE_16);
	endfunction

	always_comb begin
		nxt_init_cnt = init_cnt_ff;
		if (init_cnt_ff != 8'h00) begin
			nxt_init_cnt = init_cnt_ff - 8'h01;
		end
		nxt_selftest = selftest_ff;
		nxt_zq_cal_active = zq_cal_active_ff;
		if (zq_cal_start && !factory_trim_ff) begin
			nxt_zq_cal_active = 1'b1;
		end
		if (zq_cal_done && zq_cal_active_ff) begin
			nxt_zq_cal_active = 1'b0;
			if (SELFTEST_SUPPORTED) begin
				nxt_selftest = zq_pin_sense;
			end
		end
		nxt_factory_trim = (nxt_selftest == ST_SUPPLY_OR_FLOAT) ||
			(nxt_selftest == ST_GROUND_SHORT);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_cnt_ff <= INIT_CYCLES;
			selftest_ff <= ST_NOT_SUPPORTED;
			factory_trim_ff <= 1'b0;
			zq_cal_active_ff <= 1'b0;
		end else begin
			init_cnt_ff <= nxt_init_cnt;
			selftest_ff <= nxt_selftest;
			factory_trim_ff <= nxt_factory_trim;
			zq_cal_active_ff <= nxt_zq_cal_active;
		end
	end

	always_comb begin
		nxt_burst_setup = burst_setup_ff;
		nxt_rd_valid = 1'b0;
		nxt_rd_data = 8'h00;
		if (cmd.valid && cmd.write && cmd.addr == ADDR_BURST_SETUP) begin
			nxt_burst_setup = sdmr_burst_setup_t'(cmd.wdata);
		end
		if (cmd.valid && !cmd.write) begin
			nxt_rd_valid = 1'b1;
			if (cmd.addr == ADDR_DEVICE_INFO) begin
				nxt_rd_data[AUTO_INIT_BIT] = (init_cnt_ff != 8'h00);
				nxt_rd_data[DEV_TYPE_BIT] = DEVICE_IS_NVM;
				nxt_rd_data[INVALID_DATA_BIT] = 1'b0;
				nxt_rd_data[SELFTEST_LSB +: 2] = selftest_ff;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			burst_setup_ff <= sdmr_burst_setup_t'(BURST_SETUP_RESET);
			rd_valid_ff <= 1'b0;
			rd_data_ff <= 8'h00;
		end else begin
			burst_setup_ff <= nxt_burst_setup;
			rd_valid_ff <= nxt_rd_valid;
			rd_data_ff <= nxt_rd_data;
		end
	end

	always_comb begin
		nxt_wr_cnt = wr_cnt_ff;
		nxt_precharge_start = 1'b0;
		if (wr_ap_end) begin
			nxt_wr_cnt = wr_cycles(burst_setup_ff.write_recovery_count);
		end else if (wr_cnt_ff != 4'h0) begin
			nxt_wr_cnt = wr_cnt_ff - 4'h1;
			nxt_precharge_start = (wr_cnt_ff == 4'h1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_cnt_ff <= 4'h0;
			precharge_start_ff <= 1'b0;
		end else begin
			wr_cnt_ff <= nxt_wr_cnt;
			precharge_start_ff <= nxt_precharge_start;
		end
	end

	assign even_col = {start_col[3:1], 1'b0};

	sdmr_burst_order u_order (
		.start_col(even_col),
		.beat(beat),
		.eight_beat(burst_setup_ff.burst_length == BL_CODE_8),
		.interleaved(burst_setup_ff.burst_type),
		.no_wrap(burst_setup_ff.wrap_control),
		.col(order_col)
	);

	always_comb begin
		nxt_beat_col = beat_col_ff;
		nxt_burst_status = burst_status_ff;
		if (burst_start) begin
			nxt_beat_col = order_col;
			nxt_burst_status = SDMR_OK;
			if (!bl_legal(burst_setup_ff.burst_length) ||
				burst_setup_ff.write_recovery_count < WR_CODE_MIN ||
				burst_setup_ff.write_recovery_count > WR_CODE_MAX) begin
				nxt_burst_status = SDMR_RESERVED_CODE;
			end else if (burst_setup_ff.wrap_control &&
				burst_setup_ff.burst_length != BL_CODE_4) begin
				nxt_burst_status = SDMR_NOWRAP_ILLEGAL;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			beat_col_ff <= 4'h0;
			burst_status_ff <= SDMR_OK;
		end else begin
			beat_col_ff <= nxt_beat_col;
			burst_status_ff <= nxt_burst_status;
		end
	end
endmodule

// ==== pkg/sdmr_pkg.sv ====
// Purpose: Shared constants and types for the mode-register and burst-order block.
// Assumes: One clock; mode-register commands arrive already decoded.
// Notes: Field positions and codes follow the device information and burst setup layouts.
package sdmr_pkg;
	localparam logic [7:0] ADDR_DEVICE_INFO = 8'h00;
	localparam logic [7:0] ADDR_BURST_SETUP = 8'h01;
	localparam int AUTO_INIT_BIT = 0;
	localparam int DEV_TYPE_BIT = 1;
	localparam int INVALID_DATA_BIT = 2;
	localparam int SELFTEST_LSB = 3;
	localparam int BL_LSB = 0;
	localparam int BT_BIT = 3;
	localparam int WRAP_BIT = 4;
	localparam int WR_LSB = 5;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] BL_CODE_16 = 3'h4;
	localparam logic [2:0] WR_CODE_MIN = 3'h1;
	localparam logic [2:0] WR_CODE_MAX = 3'h6;
	localparam logic [3:0] WR_CODE_OFFSET = 4'h2;
	localparam logic [7:0] BURST_SETUP_RESET = 8'h22;
	localparam logic [1:0] ST_NOT_SUPPORTED = 2'h0;
	localparam logic [1:0] ST_SUPPLY_OR_FLOAT = 2'h1;
	localparam logic [1:0] ST_GROUND_SHORT = 2'h2;
	localparam logic [1:0] ST_PASS = 2'h3;
	localparam logic [7:0] DEFAULT_INIT_CYCLES = 8'h10;

	typedef struct packed {
		logic [2:0] write_recovery_count;
		logic wrap_control;
		logic burst_type;
		logic [2:0] burst_length;
	} sdmr_burst_setup_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sdmr_cmd_t;

	typedef enum logic [1:0] {
		SDMR_OK,
		SDMR_RESERVED_CODE,
		SDMR_NOWRAP_ILLEGAL
	} sdmr_burst_status_t;
endpackage

// ==== rtl/sdmr_burst_order.sv ====
// Purpose: Computes the column offset for one beat of a burst.
// Assumes: Start column bit 0 is already forced to zero.
// Notes: Pure combinational ordering for 4 and 8 beat bursts.
`timescale 1ns/1ps
module sdmr_burst_order (
	input wire logic [3:0] start_col,
	input wire logic [3:0] beat,
	input wire logic eight_beat,
	input wire logic interleaved,
	input wire logic no_wrap,
	output logic [3:0] col
);
	always_comb begin
		col = start_col;
		if (!eight_beat) begin
			if (no_wrap) begin
				col = start_col + beat;
			end else begin
				col = {start_col[3:2], start_col[1:0] ^ {beat[1], 1'b0} ^ {1'b0, beat[0]}};
			end
		end else if (interleaved) begin
			col = {start_col[3], start_col[2:0] ^ beat[2:0]};
		end else begin
			col = {start_col[3], 3'(start_col[2:0] + beat[2:0])};
		end
	end
endmodule

// ==== dv/sdmr_ctrl_model.sv ====
// Purpose: Controller model issuing mode-register commands.
// Assumes: One command per go pulse.
// Notes: Idle data is the inverse of the last value.
`timescale 1ns/1ps
module sdmr_ctrl_model (
	input wire logic clk,
	input wire logic go,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	output sdmr_pkg::sdmr_cmd_t cmd
);
	import sdmr_pkg::*;
	initial cmd = '0;
	always @(posedge clk) begin
		cmd <= '{go, wr, addr, go ? wdata : ~cmd.wdata};
	end
endmodule

// ==== dv/sdmr_regs_chk.sv ====
// Purpose: Port checks of the mode-register block.
// Assumes: Package codes.
// Notes: Bound to sdmr_regs.
`timescale 1ns/1ps
module sdmr_regs_chk (
	input wire logic clk,
	input wire logic arst_n,
	input sdmr_pkg::sdmr_cmd_t cmd,
	input wire logic zq_cal_done,
	input wire logic [1:0] zq_pin_sense,
	input wire logic wr_ap_end,
	input wire logic burst_start,
	input wire logic rd_valid_ff,
	input wire logic [7:0] rd_data_ff,
	input sdmr_pkg::sdmr_burst_setup_t burst_setup_ff,
	input wire logic factory_trim_ff,
	input wire logic zq_cal_active_ff,
	input wire logic precharge_start_ff,
	input sdmr_pkg::sdmr_burst_status_t burst_status_ff
);
	import sdmr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	read_answer_a: assert property (cmd.valid && !cmd.write |=> rd_valid_ff)
		else $error("read lost");
	read_only_a: assert property (!(cmd.valid && !cmd.write) |=> !rd_valid_ff)
		else $error("stray read");
	reserved_zero_a: assert property (rd_valid_ff |-> !rd_data_ff[7:5] && !rd_data_ff[2])
		else $error("bad zero bits");
	setup_write_a: assert property (cmd.valid && cmd.write && cmd.addr == 8'h01
		|=> burst_setup_ff == $past(cmd.wdata)) else $error("setup lost");
	setup_hold_a: assert property (!(cmd.valid && cmd.write && cmd.addr == 8'h01)
		|=> $stable(burst_setup_ff)) else $error("setup moved");
	trim_select_a: assert property (zq_cal_done && zq_cal_active_ff
		|=> factory_trim_ff == ^$past(zq_pin_sense)) else $error("bad trim");
	precharge_wait_a: assert property (wr_ap_end && burst_setup_ff[7:5] == 3'h1
		|=> !precharge_start_ff [*3] ##1 precharge_start_ff) else $error("bad precharge");
	nowrap_flag_a: assert property (burst_start && burst_setup_ff == 8'h53
		|=> burst_status_ff == SDMR_NOWRAP_ILLEGAL) else $error("no flag");
endmodule
bind sdmr_regs sdmr_regs_chk chk (.*);

// ==== dv/sdram_mode_reg_burst_order_bench.sv ====
// Purpose: Self-checking bench of the mode-register block.
// Assumes: 200 MHz clock, seed 6.
// Notes: Commands go through the controller model.
`timescale 1ns/1ps
module sdram_mode_reg_burst_order_bench;
	import sdmr_pkg::*;
	logic clk = 0, arst_n = 0, go = 0, wr = 0, zq_cal_start = 0, zq_cal_done = 0;
	logic wr_ap_end = 0, burst_start = 0, rd_valid_ff, factory_trim_ff;
	logic zq_cal_active_ff, precharge_start_ff;
	logic [1:0] zq_pin_sense = 2'h0;
	logic [3:0] start_col = 4'h0, beat = 4'h0, beat_col_ff;
	logic [7:0] addr = 8'h00, wdata = 8'h00, d, rd_data_ff;
	logic [2:0] bls [4] = '{3'h2, 3'h3, 3'h4, 3'h7};
	int miscompares = 0, n_checks = 0, cycles = 0, k;
	sdmr_cmd_t cmd;
	sdmr_burst_setup_t burst_setup_ff;
	sdmr_burst_status_t burst_status_ff;
	sdmr_ctrl_model ctrl (.*);
	sdmr_regs uut (.*);
	initial begin
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [8:0] g, input logic [8:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic mr(input logic w, input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(w ? {1'b0, burst_setup_ff} : {rd_valid_ff, rd_data_ff}, {!w, e});
		@(posedge clk);
	endtask
	task automatic pulse_cal(input logic done);
		zq_cal_start <= 1'b1;
		@(posedge clk);
		zq_cal_start <= 1'b0;
		zq_cal_done <= done;
		@(posedge clk);
		zq_cal_done <= 1'b0;
	endtask
	function automatic logic [3:0] col(logic [7:0] d, logic [3:0] s, logic [3:0] b);
		s[0] = 1'b0;
		if (d[2:0] == 3'h2)
			return d[4] ? s + b : {s[3:2], s[1:0] + b[1:0]};
		return {s[3], d[3] ? s[2:0] ^ b[2:0] : s[2:0] + b[2:0]};
	endfunction
	initial begin
		void'($urandom(6));
		for (int c = 0; c < 4; c++) begin
			arst_n <= 1'b0;
			repeat (16) @(posedge clk);
			arst_n <= 1'b1;
			@(posedge clk);
			mr(1'b0, 8'h00, 8'h00, 8'h01);
			chk({1'b0, burst_setup_ff}, {1'b0, BURST_SETUP_RESET});
			repeat (16) @(posedge clk);
			zq_pin_sense <= c[1:0];
			pulse_cal(1'b1);
			@(negedge clk);
			chk({8'h00, factory_trim_ff}, {8'h00, ^c[1:0]});
			@(posedge clk);
			mr(1'b0, 8'h00, 8'h00, {3'h0, c[1:0], 3'h0});
			pulse_cal(1'b0);
			@(negedge clk);
			chk({8'h00, zq_cal_active_ff}, {8'h00, ~^c[1:0]});
			@(posedge clk);
		end
		mr(1'b1, 8'h00, 8'hFF, BURST_SETUP_RESET);
		mr(1'b0, 8'h01, 8'h00, 8'h00);
		for (int c = 1; c < 7; c++) begin
			mr(1'b1, 8'h01, {c[2:0], 5'h02}, {c[2:0], 5'h02});
			wr_ap_end <= 1'b1;
			@(posedge clk);
			wr_ap_end <= 1'b0;
			for (k = 0; k < 12 && precharge_start_ff !== 1'b1; k++) @(negedge clk);
			chk(9'(k), 9'(c + 3));
			@(posedge clk);
		end
		for (int i = 0; i < 60; i++) begin
			d = {3'($urandom_range(6, 1)), 2'($urandom), bls[i % 4]};
			if (i == 0) d = 8'h53;
			mr(1'b1, 8'h01, d, d);
			start_col <= 4'($urandom);
			beat <= 4'($urandom_range(d[0] ? 7 : 3));
			burst_start <= 1'b1;
			@(posedge clk);
			burst_start <= 1'b0;
			@(negedge clk);
			if (d[2:0] == 3'h7) chk(9'(burst_status_ff), 9'(SDMR_RESERVED_CODE));
			else if (d[2:0] == 3'h3 && d[4]) chk(9'(burst_status_ff), 9'(SDMR_NOWRAP_ILLEGAL));
			else if (d[2:0] == 3'h4) chk(9'(burst_status_ff),
				9'(d[4] ? SDMR_NOWRAP_ILLEGAL : SDMR_OK));
			else chk({3'h0, burst_status_ff, beat_col_ff},
				{3'h0, SDMR_OK, col(d, start_col, beat)});
			@(posedge clk);
		end
		results();
	end
endmodule
